/* common/adc_seq_pkg.sv */
// Purpose: Shared constants for the channel-gain sequencer.
// Assumes: 32-bit register port with byte addresses, one word per register.
// Notes:   Gain tables hold the amplifier factor for each two-bit gain code.
package adc_seq_pkg;
    localparam int RESULT_W     = 12;
    localparam int RESULT_CODES = 4096;
    localparam int QUEUE_DEPTH  = 256;
    localparam int CH_W         = 8;
    localparam int GAIN_W       = 2;
    localparam int ENTRY_W      = CH_W + GAIN_W;
    localparam int ONBOARD_SE   = 16;
    localparam int ONBOARD_DIFF = 8;
    localparam int EXP_UNITS    = 16;
    localparam int ADDR_W       = 8;
    localparam int DATA_W       = 32;

    localparam logic [7:0] OFS_CFG    = 8'h00;
    localparam logic [7:0] OFS_QADDR  = 8'h04;
    localparam logic [7:0] OFS_QDATA  = 8'h08;
    localparam logic [7:0] OFS_QLAST  = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_RESULT = 8'h14;

    localparam int CFG_DIFF_BIT    = 0;
    localparam int CFG_UCOM_BIT    = 1;
    localparam int CFG_BIPOLAR_BIT = 2;
    localparam int CFG_RUN_BIT     = 3;
    localparam int CFG_W           = 4;
    localparam int QDATA_CH_LSB    = 0;
    localparam int QDATA_GAIN_LSB  = 8;
    localparam int STATUS_RUN_BIT  = 8;

    localparam logic [3:0]  CFG_RST      = 4'h0;
    localparam logic [7:0]  QADDR_RST    = 8'h00;
    localparam logic [7:0]  QLAST_RST    = 8'h00;
    localparam logic [11:0] BIPOLAR_FLIP = 12'h800;

    localparam logic [7:0] GAIN_HI_0 = 8'h01;
    localparam logic [7:0] GAIN_HI_1 = 8'h05;
    localparam logic [7:0] GAIN_HI_2 = 8'h32;
    localparam logic [7:0] GAIN_HI_3 = 8'hFA;
    localparam logic [7:0] GAIN_LO_0 = 8'h01;
    localparam logic [7:0] GAIN_LO_1 = 8'h02;
    localparam logic [7:0] GAIN_LO_2 = 8'h04;
    localparam logic [7:0] GAIN_LO_3 = 8'h08;
endpackage

/* hdl/adc_channel_gain_sequencer.sv */
// Purpose: Channel-gain queue and input-mode control for a 12-bit sampling converter.
// Assumes: The converter reports each finished sample with a rising edge on
//          i_conv_done whose data stay stable for at least four clocks afterwards.
// Notes:   Converter data arrive offset binary; bipolar results are recoded here.
// Overview of operation
// RULE_01: Each conversion result is twelve bits wide, 4096 codes over the range.
// RULE_02: All onboard channels share one multiplexer, 16 single-ended or 8 differential.
// RULE_03: A configuration bit selects differential or single-ended onboard inputs.
// RULE_04: Single-ended low side goes to analog ground, or to user common when chosen.
// RULE_05: A configuration bit selects unipolar or bipolar input mode.
// RULE_06: Unipolar results are plain binary, bipolar results are two's complement.
// RULE_07: The queue holds 256 entries, each a channel number and its gain code.
// RULE_08: Entries may be in any order, repeat channels and use any gains.
// RULE_09: In single-ended mode, 16 expansion units give up to 256 channels.
// RULE_10: Four expansion select outputs carry channel bits 4 to 7 of the entry.
// RULE_11: One expansion gain output from the entry selects gain 1 or 50.
// RULE_12: High-gain variant offers gains 1, 5, 50 and 250.
// RULE_13: Low-gain variant offers gains 1, 2, 4 and 8.
// RULE_14: After each conversion advance; after the last entry wrap to the first.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module adc_channel_gain_sequencer #(
    parameter int   QDEPTH    = adc_seq_pkg::QUEUE_DEPTH,
    parameter logic HIGH_GAIN = 1'b1
) (
    input  wire logic                                 i_mclk,
    input  wire logic                                 i_rst_n,
    input  wire logic [adc_seq_pkg::ADDR_W-1:0]       i_addr,
    input  wire logic [adc_seq_pkg::DATA_W-1:0]       i_wdata,
    input  wire logic                                 i_wr,
    input  wire logic                                 i_rd,
    output logic      [adc_seq_pkg::DATA_W-1:0]       o_rdata,
    input  wire logic                                 i_conv_done,
    input  wire logic [adc_seq_pkg::RESULT_W-1:0]     i_adc_data,
    output logic      [3:0]                           o_mux_sel,
    output logic      [3:0]                           o_expansion_channel_select,
    output logic                                      o_expansion_gain_select,
    output logic      [adc_seq_pkg::GAIN_W-1:0]       o_gain_code,
    output logic      [7:0]                           o_gain_value,
    output logic                                      o_diff_mode,
    output logic                                      o_analog_ground_ref,
    output logic                                      o_user_common_ref,
    output logic                                      o_bipolar,
    output logic      [adc_seq_pkg::RESULT_W-1:0]     o_result,
    output logic                                      o_result_valid
);
    localparam int IDX_W = $clog2(QDEPTH);

    generate
        if (QDEPTH < 2 || QDEPTH > adc_seq_pkg::QUEUE_DEPTH || (1 << IDX_W) != QDEPTH) begin : g_chk
            $error("QDEPTH must be a power of two between 2 and 256");
        end
    endgenerate

    function automatic logic [7:0] gain_value(input logic [1:0] code, input logic hi);
        logic [7:0] v;
        v = 8'h00;
        unique case (code)
            2'h0: v = hi ? adc_seq_pkg::GAIN_HI_0 : adc_seq_pkg::GAIN_LO_0;
            2'h1: v = hi ? adc_seq_pkg::GAIN_HI_1 : adc_seq_pkg::GAIN_LO_1;
            2'h2: v = hi ? adc_seq_pkg::GAIN_HI_2 : adc_seq_pkg::GAIN_LO_2;
            2'h3: v = hi ? adc_seq_pkg::GAIN_HI_3 : adc_seq_pkg::GAIN_LO_3;
        endcase
        return v;
    endfunction

    logic [adc_seq_pkg::CFG_W-1:0]   cfg_reg;
    logic [IDX_W-1:0]                qaddr_reg;
    logic [IDX_W-1:0]                qlast_reg;
    logic [IDX_W-1:0]                idx_reg;
    logic [adc_seq_pkg::ENTRY_W-1:0] queue_reg [QDEPTH];
    logic [adc_seq_pkg::ENTRY_W-1:0] cur_entry;
    logic [adc_seq_pkg::CH_W-1:0]    cur_ch;
    logic [1:0]                      cur_gain;
    logic                            done_s1_reg;
    logic                            done_s2_reg;
    logic                            done_s3_reg;
    logic                            conv_edge;
    logic                            wr_cfg;
    logic                            wr_qaddr;
    logic                            wr_qdata;
    logic                            wr_qlast;
    logic                            run;
    logic                            diff;
    logic [adc_seq_pkg::DATA_W-1:0]  rdata_next;

    assign wr_cfg    = i_wr && (i_addr == adc_seq_pkg::OFS_CFG);
    assign wr_qaddr  = i_wr && (i_addr == adc_seq_pkg::OFS_QADDR);
    assign wr_qdata  = i_wr && (i_addr == adc_seq_pkg::OFS_QDATA);
    assign wr_qlast  = i_wr && (i_addr == adc_seq_pkg::OFS_QLAST);
    assign run       = cfg_reg[adc_seq_pkg::CFG_RUN_BIT];
    assign diff      = cfg_reg[adc_seq_pkg::CFG_DIFF_BIT];
    assign cur_entry = queue_reg[idx_reg];
    assign cur_ch    = cur_entry[adc_seq_pkg::QDATA_CH_LSB +: adc_seq_pkg::CH_W];
    assign cur_gain  = cur_entry[adc_seq_pkg::QDATA_GAIN_LSB +: adc_seq_pkg::GAIN_W];
    assign conv_edge = done_s2_reg && !done_s3_reg;

    // Configuration word: input type, ground reference, coding and sequencer run.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_reg <= adc_seq_pkg::CFG_RST;
        end else if (wr_cfg) begin
            cfg_reg <= i_wdata[adc_seq_pkg::CFG_W-1:0]; // RULE_03 RULE_05
        end
    end

    // Queue pointer for software access; each data write steps it by one.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            qaddr_reg <= adc_seq_pkg::QADDR_RST[IDX_W-1:0];
            qlast_reg <= adc_seq_pkg::QLAST_RST[IDX_W-1:0];
        end else begin
            if (wr_qaddr) begin
                qaddr_reg <= i_wdata[IDX_W-1:0];
            end else if (wr_qdata) begin
                qaddr_reg <= IDX_W'(qaddr_reg + 1'b1);
            end
            if (wr_qlast) begin
                qlast_reg <= i_wdata[IDX_W-1:0];
            end
        end
    end

    // Queue storage accepts any channel and gain in any order. It clears on reset so that
    // the select and gain outputs are never unknown before software fills the queue.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < QDEPTH; i++) begin
                queue_reg[i] <= '0;
            end
        end else if (wr_qdata) begin
            queue_reg[qaddr_reg] <= i_wdata[adc_seq_pkg::ENTRY_W-1:0]; // RULE_07 RULE_08
        end
    end

    // The done line comes from the converter and is synchronised before use.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            done_s1_reg <= 1'b0;
            done_s2_reg <= 1'b0;
            done_s3_reg <= 1'b0;
        end else begin
            done_s1_reg <= i_conv_done;
            done_s2_reg <= done_s1_reg;
            done_s3_reg <= done_s2_reg;
        end
    end

    // Sequencer position: held at the first entry while stopped.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idx_reg <= '0;
        end else if (!run) begin
            idx_reg <= '0;
        end else if (conv_edge) begin
            idx_reg <= (idx_reg == qlast_reg) ? '0 : IDX_W'(idx_reg + 1'b1); // RULE_14
        end
    end

    // Result capture and coding.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_result       <= '0;
            o_result_valid <= 1'b0;
        end else begin
            o_result_valid <= conv_edge;
            if (conv_edge) begin
                o_result <= cfg_reg[adc_seq_pkg::CFG_BIPOLAR_BIT] ?
                            (i_adc_data ^ adc_seq_pkg::BIPOLAR_FLIP) : i_adc_data; // RULE_01 RULE_06
            end
        end
    end

    // Front-end and expansion lines follow the current entry one clock later.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mux_sel                  <= 4'h0;
            o_expansion_channel_select <= 4'h0;
            o_expansion_gain_select    <= 1'b0;
            o_gain_code                <= 2'h0;
            o_gain_value               <= adc_seq_pkg::GAIN_HI_0;
            o_diff_mode                <= 1'b0;
            o_analog_ground_ref        <= 1'b1;
            o_user_common_ref          <= 1'b0;
            o_bipolar                  <= 1'b0;
        end else begin
            o_mux_sel                  <= diff ? {1'b0, cur_ch[2:0]} : cur_ch[3:0]; // RULE_02
            o_expansion_channel_select <= diff ? 4'h0 : cur_ch[7:4]; // RULE_09 RULE_10
            o_expansion_gain_select    <= cur_gain[1]; // RULE_11
            o_gain_code                <= cur_gain;
            o_gain_value               <= gain_value(cur_gain, HIGH_GAIN); // RULE_12 RULE_13
            o_diff_mode                <= diff;
            o_analog_ground_ref        <= !diff && !cfg_reg[adc_seq_pkg::CFG_UCOM_BIT]; // RULE_04
            o_user_common_ref          <= !diff && cfg_reg[adc_seq_pkg::CFG_UCOM_BIT]; // RULE_04
            o_bipolar                  <= cfg_reg[adc_seq_pkg::CFG_BIPOLAR_BIT];
        end
    end

    // Read data stand for exactly one cycle after the strobe; unmapped reads return zero.
    always_comb begin
        rdata_next = '0;
        unique case (i_addr)
            adc_seq_pkg::OFS_CFG:    rdata_next[adc_seq_pkg::CFG_W-1:0] = cfg_reg;
            adc_seq_pkg::OFS_QADDR:  rdata_next[IDX_W-1:0] = qaddr_reg;
            adc_seq_pkg::OFS_QDATA:  rdata_next[adc_seq_pkg::ENTRY_W-1:0] = queue_reg[qaddr_reg];
            adc_seq_pkg::OFS_QLAST:  rdata_next[IDX_W-1:0] = qlast_reg;
            adc_seq_pkg::OFS_STATUS: begin
                rdata_next[IDX_W-1:0] = idx_reg;
                rdata_next[adc_seq_pkg::STATUS_RUN_BIT] = run;
            end
            adc_seq_pkg::OFS_RESULT: rdata_next[adc_seq_pkg::RESULT_W-1:0] = o_result;
            default:                 rdata_next = '0;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= i_rd ? rdata_next : '0;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    property p_result_code;
        conv_edge |=> o_result == (o_bipolar ? ($past(i_adc_data) ^ adc_seq_pkg::BIPOLAR_FLIP)
                                             : $past(i_adc_data));
    endproperty
    a_result_code: assert property (p_result_code) else $error("result coding wrong"); // RULE_06

    property p_result_pulse;
        conv_edge |=> o_result_valid ##1 !o_result_valid;
    endproperty
    a_result_pulse: assert property (p_result_pulse) else $error("result strobe wrong"); // RULE_01

    property p_wrap;
        run && conv_edge && (idx_reg == qlast_reg) && !wr_cfg |=> idx_reg == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("queue did not wrap"); // RULE_14

    property p_advance;
        run && conv_edge && (idx_reg != qlast_reg) && !wr_cfg
            |=> idx_reg == IDX_W'($past(idx_reg) + 1'b1);
    endproperty
    a_advance: assert property (p_advance) else $error("queue did not advance"); // RULE_14

    property p_diff_mux;
        o_diff_mode |-> (o_mux_sel[3] == 1'b0) && (o_expansion_channel_select == 4'h0);
    endproperty
    a_diff_mux: assert property (p_diff_mux) else $error("differential select out of range"); // RULE_02

    property p_ground;
        !o_diff_mode |-> o_analog_ground_ref != o_user_common_ref;
    endproperty
    a_ground: assert property (p_ground) else $error("ground reference not exclusive"); // RULE_04

    property p_ext_gain;
        o_expansion_gain_select == o_gain_code[1];
    endproperty
    a_ext_gain: assert property (p_ext_gain) else $error("expansion gain mismatch"); // RULE_11

    property p_gain_table;
        o_gain_value == gain_value(o_gain_code, HIGH_GAIN);
    endproperty
    a_gain_table: assert property (p_gain_table) else $error("gain value mismatch"); // RULE_12

    property p_cfg_out;
        wr_cfg |=> ##1 (o_diff_mode == $past(i_wdata[adc_seq_pkg::CFG_DIFF_BIT], 2))
                    && (o_bipolar == $past(i_wdata[adc_seq_pkg::CFG_BIPOLAR_BIT], 2));
    endproperty
    a_cfg_out: assert property (p_cfg_out) else $error("mode outputs did not follow"); // RULE_03

    property p_queue_store;
        wr_qdata |=> queue_reg[$past(qaddr_reg)] == $past(i_wdata[adc_seq_pkg::ENTRY_W-1:0]);
    endproperty
    a_queue_store: assert property (p_queue_store) else $error("queue entry not stored"); // RULE_07

    property p_exp_sel;
        !diff ##1 !diff |-> o_expansion_channel_select == $past(cur_ch[7:4]);
    endproperty
    a_exp_sel: assert property (p_exp_sel) else $error("expansion select mismatch"); // RULE_10

    // Register port, front-end outputs and sequencer hold behaviour.
    property p_rdata_idle;
        !i_rd |=> o_rdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle"); // RULE_07

    property p_rd_status;
        i_rd && (i_addr == adc_seq_pkg::OFS_STATUS) |=> o_rdata[IDX_W-1:0] == $past(idx_reg);
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status readback wrong"); // RULE_14

    property p_mux_se;
        !diff |=> o_mux_sel == $past(cur_ch[3:0]);
    endproperty
    a_mux_se: assert property (p_mux_se) else $error("onboard select mismatch"); // RULE_02

    property p_ucom_follow;
        !diff && cfg_reg[adc_seq_pkg::CFG_UCOM_BIT] |=> o_user_common_ref && !o_analog_ground_ref;
    endproperty
    a_ucom_follow: assert property (p_ucom_follow) else $error("user common not chosen"); // RULE_04

    property p_diff_refs;
        diff |=> !o_analog_ground_ref && !o_user_common_ref;
    endproperty
    a_diff_refs: assert property (p_diff_refs) else $error("reference set in diff mode"); // RULE_03

    property p_bipolar_follow;
        o_bipolar == $past(cfg_reg[adc_seq_pkg::CFG_BIPOLAR_BIT]);
    endproperty
    a_bipolar_follow: assert property (p_bipolar_follow) else $error("coding mode lag"); // RULE_05

    property p_stop_hold;
        !run |=> idx_reg == '0;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stopped queue moved"); // RULE_14

    property p_idx_hold;
        run && !conv_edge |=> idx_reg == $past(idx_reg);
    endproperty
    a_idx_hold: assert property (p_idx_hold) else $error("queue moved without sample"); // RULE_14

    property p_result_hold;
        !conv_edge |=> $stable(o_result);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result changed idle"); // RULE_01

    property p_qaddr_step;
        wr_qdata |=> qaddr_reg == IDX_W'($past(qaddr_reg) + 1'b1);
    endproperty
    a_qaddr_step: assert property (p_qaddr_step) else $error("queue pointer did not step"); // RULE_07

    property p_gain_follow;
        o_gain_code == $past(cur_gain);
    endproperty
    a_gain_follow: assert property (p_gain_follow) else $error("gain code lag"); // RULE_12

    property p_exp_gain_follow;
        o_expansion_gain_select == $past(cur_gain[1]);
    endproperty
    a_exp_gain_follow: assert property (p_exp_gain_follow) else $error("ext gain lag"); // RULE_11

    c_wrap:    cover property (run && conv_edge && idx_reg == qlast_reg && idx_reg != '0);
    c_bipolar: cover property (o_bipolar && o_result_valid);
    c_diff:    cover property (o_diff_mode && o_result_valid);
    c_ucom:    cover property (o_user_common_ref && o_expansion_gain_select);
    c_stopped: cover property (!run && conv_edge);
endmodule

/* testbench/adc_front_model.sv */
// Purpose: Behavioural converter front end that answers conversion requests from the bench.
// Assumes: One request at a time, spaced at least eight clocks apart.
// Notes:   Sample data turn to their inverse once the hold time has run out.
`timescale 1ns/1ps
module adc_front_model (
    input  wire logic        i_mclk,
    input  wire logic        i_start,
    input  wire logic [11:0] i_sample,
    output logic             o_conv_done,
    output logic      [11:0] o_adc_data
);
    logic [3:0] cnt_reg;
    initial begin
        o_conv_done = 1'b0;
        o_adc_data  = 12'h000;
        cnt_reg     = 4'h0;
    end
    // Done stays high four clocks, then low at least four; data hold six clocks past the rise.
    always @(posedge i_mclk) begin
        if (i_start) begin
            o_adc_data  <= i_sample;
            o_conv_done <= 1'b1;
            cnt_reg     <= 4'h1;
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= (cnt_reg == 4'h8) ? 4'h0 : cnt_reg + 4'h1;
            if (cnt_reg == 4'h4) o_conv_done <= 1'b0;
            if (cnt_reg == 4'h6) o_adc_data <= ~o_adc_data;
        end
    end
endmodule

/* testbench/tb_adc_channel_gain_sequencer.sv */
// Purpose: Self-checking bench for the channel-gain sequencer.
// Assumes: Converter front end is the behavioural model; both gain variants are built.
// Notes:   Queue entries are written before the sequencer is started.
`timescale 1ns/1ps
module tb_adc_channel_gain_sequencer;
    logic        i_mclk, i_rst_n, i_wr, i_rd, start, conv_done;
    logic [7:0]  i_addr, o_gval, lo_gval;
    logic [31:0] i_wdata, o_rdata;
    logic [11:0] sample, adc_data, o_result;
    logic [3:0]  o_mux_sel, o_exp;
    logic [1:0]  o_gcode;
    logic        o_gsel, o_diff, o_gnd, o_ucom, o_bip, o_rvalid;
    int          err_total, tests_run;
    logic [7:0]  ch_tab [4] = '{8'hF7, 8'h00, 8'h35, 8'h35};
    logic [1:0]  g_tab  [4] = '{2'h3, 2'h0, 2'h2, 2'h1};
    logic [7:0]  hi_tab [4] = '{adc_seq_pkg::GAIN_HI_0, adc_seq_pkg::GAIN_HI_1,
                                adc_seq_pkg::GAIN_HI_2, adc_seq_pkg::GAIN_HI_3};
    logic [7:0]  lo_tab [4] = '{adc_seq_pkg::GAIN_LO_0, adc_seq_pkg::GAIN_LO_1,
                                adc_seq_pkg::GAIN_LO_2, adc_seq_pkg::GAIN_LO_3};
    logic [11:0] smp    [5] = '{12'h000, 12'hFFF, 12'h5A5, 12'h123, 12'hABC};

    adc_front_model model_u (.i_mclk(i_mclk), .i_start(start), .i_sample(sample),
        .o_conv_done(conv_done), .o_adc_data(adc_data));
    adc_channel_gain_sequencer dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_conv_done(conv_done), .i_adc_data(adc_data), .o_mux_sel(o_mux_sel),
        .o_expansion_channel_select(o_exp), .o_expansion_gain_select(o_gsel),
        .o_gain_code(o_gcode), .o_gain_value(o_gval), .o_diff_mode(o_diff),
        .o_analog_ground_ref(o_gnd), .o_user_common_ref(o_ucom), .o_bipolar(o_bip),
        .o_result(o_result), .o_result_valid(o_rvalid));
    // The low-gain variant shares all inputs; only its gain factor is watched.
    adc_channel_gain_sequencer #(.HIGH_GAIN(1'b0)) dut_lo (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(),
        .i_conv_done(conv_done), .i_adc_data(adc_data), .o_mux_sel(),
        .o_expansion_channel_select(), .o_expansion_gain_select(), .o_gain_code(),
        .o_gain_value(lo_gval), .o_diff_mode(), .o_analog_ground_ref(), .o_user_common_ref(),
        .o_bipolar(), .o_result(), .o_result_valid());

    always #4 i_mclk = ~i_mclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_mclk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask

    task automatic conv(input logic [11:0] s, input logic [11:0] exp);
        int n;
        repeat (4) @(posedge i_mclk);
        start  <= 1'b1;
        sample <= s;
        @(posedge i_mclk);
        start <= 1'b0;
        n = 0;
        do begin
            @(posedge i_mclk);
            #1 n++;
        end while (o_rvalid !== 1'b1 && n < 12);
        chk({31'h0, o_rvalid}, 32'h1);
        chk({20'h0, o_result}, {20'h0, exp});
        @(posedge i_mclk);
        #1;
    endtask

    task automatic chk_entry(input int i);
        chk({5'h0, o_mux_sel, o_exp, o_gsel, o_gcode, o_gval, lo_gval},
            {5'h0, ch_tab[i][3:0], ch_tab[i][7:4], g_tab[i][1], g_tab[i],
             hi_tab[g_tab[i]], lo_tab[g_tab[i]]});
    endtask

    task automatic t_modes;
        for (int c = 0; c < 8; c++) begin
            wr(adc_seq_pkg::OFS_CFG, 32'(c));
            repeat (2) @(posedge i_mclk);
            #1 chk({28'h0, o_diff, o_gnd, o_ucom, o_bip},
                   {28'h0, c[0], ~c[0] & ~c[1], ~c[0] & c[1], c[2]});
            rd_chk(adc_seq_pkg::OFS_CFG, 32'(c));
        end
    endtask

    task automatic t_queue;
        wr(adc_seq_pkg::OFS_QADDR, 32'h0);
        for (int i = 0; i < 4; i++) wr(adc_seq_pkg::OFS_QDATA, {22'h0, g_tab[i], ch_tab[i]});
        rd_chk(adc_seq_pkg::OFS_QADDR, 32'h4);
        @(posedge i_mclk);
        #1 chk(o_rdata, 32'h0);
        wr(adc_seq_pkg::OFS_QADDR, 32'hFF);
        wr(adc_seq_pkg::OFS_QDATA, 32'h2AB);
        rd_chk(adc_seq_pkg::OFS_QADDR, 32'h0);
        wr(adc_seq_pkg::OFS_QADDR, 32'hFF);
        rd_chk(adc_seq_pkg::OFS_QDATA, 32'h2AB);
        rd_chk(adc_seq_pkg::OFS_QADDR, 32'hFF);
        wr(adc_seq_pkg::OFS_QADDR, 32'h2);
        rd_chk(adc_seq_pkg::OFS_QDATA, 32'h235);
        wr(adc_seq_pkg::OFS_QLAST, 32'h3);
        rd_chk(adc_seq_pkg::OFS_QLAST, 32'h3);
    endtask

    task automatic t_stopped;
        wr(adc_seq_pkg::OFS_CFG, 32'h4);
        conv(12'h000, 12'h800);
        conv(12'hFFF, 12'h7FF);
        rd_chk(adc_seq_pkg::OFS_RESULT, 32'h7FF);
        rd_chk(adc_seq_pkg::OFS_STATUS, 32'h0);
        wr(adc_seq_pkg::OFS_CFG, 32'h0);
        conv(12'hABC, 12'hABC);
    endtask

    task automatic t_sequence;
        wr(adc_seq_pkg::OFS_CFG, 32'h8);
        repeat (2) @(posedge i_mclk);
        #1 chk_entry(0);
        for (int k = 0; k < 5; k++) begin
            conv(smp[k], smp[k]);
            chk_entry((k + 1) % 4);
            rd_chk(adc_seq_pkg::OFS_STATUS, 32'h100 | 32'((k + 1) % 4));
        end
    endtask

    task automatic t_diff;
        wr(adc_seq_pkg::OFS_CFG, 32'h0);
        wr(adc_seq_pkg::OFS_CFG, 32'h9);
        repeat (2) @(posedge i_mclk);
        #1 chk({24'h0, o_mux_sel, o_exp}, 32'h70);
    endtask

    task automatic give_verdict;
        $display("Comparisons: %0d  mismatches: %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #(8 * 5000);
        err_total++;
        give_verdict();
    end

    initial begin
        {i_mclk, i_rst_n, i_wr, i_rd, start} = 5'h0;
        {i_addr, i_wdata, sample} = 52'h0;
        err_total = 0;
        tests_run = 0;
        repeat (12) @(posedge i_mclk);
        #1 chk({13'h0, o_mux_sel, o_exp, o_gsel, o_gcode, o_gval}, 32'h1);
        chk({15'h0, o_diff, o_gnd, o_ucom, o_bip, o_result, o_rvalid}, 32'h8000);
        @(posedge i_mclk);
        i_rst_n <= 1'b1;
        rd_chk(adc_seq_pkg::OFS_STATUS, 32'h0);
        wr(8'h18, 32'hFFFF);
        rd_chk(8'h18, 32'h0);
        t_modes();
        t_queue();
        t_stopped();
        t_sequence();
        t_diff();
        give_verdict();
    end
endmodule
